// *** rtl/tlcr_pkg.sv ***
// Package: register map, field layouts and types for the link configuration bank
package tlcr_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_LINK_RATE = 12'h000;
	localparam logic [11:0] OFF_LANES = 12'h004;
	localparam logic [11:0] OFF_ENH_FRAME = 12'h008;
	localparam logic [11:0] OFF_TRAIN = 12'h00C;
	localparam logic [11:0] OFF_QUAL = 12'h010;
	localparam logic [11:0] OFF_SCR_BYP = 12'h014;
	localparam logic [11:0] OFF_SOFT_RST = 12'h01C;
	localparam logic [11:0] OFF_PAT_LOW = 12'h020;
	localparam logic [11:0] OFF_PAT_MID = 12'h024;
	localparam logic [11:0] OFF_PAT_HIGH = 12'h028;
	localparam int RATE_W = 8;
	localparam int LANES_W = 5;
	localparam int TRAIN_W = 2;
	localparam int QUAL_W = 3;
	localparam int PAT_HIGH_W = 16;
	localparam int SRST_VID_LSB = 0;
	localparam int SRST_AUX_BIT = 7;
	localparam logic [7:0] RATE_1G62 = 8'h06;
	localparam logic [7:0] RATE_2G7 = 8'h0A;
	localparam logic [7:0] RATE_5G4 = 8'h14;
	localparam logic [4:0] LANES_1 = 5'h01;
	localparam logic [4:0] LANES_2 = 5'h02;
	localparam logic [4:0] LANES_4 = 5'h04;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam int SRST_PULSE_CYCLES = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {TLCR_TRAIN_OFF, TLCR_TRAIN_TPS1, TLCR_TRAIN_TPS2, TLCR_TRAIN_TPS3}
		tlcr_train_e;
	typedef enum logic [2:0] {TLCR_QUAL_NONE, TLCR_QUAL_D10_2, TLCR_QUAL_SER, TLCR_QUAL_PRBS7,
		TLCR_QUAL_CUSTOM, TLCR_QUAL_HBR2, TLCR_QUAL_RSVD6, TLCR_QUAL_RSVD7} tlcr_qual_e;

	typedef struct packed {
		logic [7:0] link_rate_select;
		logic [4:0] active_lane_number;
		logic enhanced_framing_on;
		tlcr_train_e training_sequence_select;
		tlcr_qual_e quality_test_select;
		logic scrambler_bypass;
		logic [79:0] custom_pattern;
	} tlcr_cfg_s;
endpackage : tlcr_pkg

// *** rtl/tlcr_regs.sv ***
// Link configuration register bank with AXI4-Lite slave and link-side delivery
// Operation
// - Registers sit on the AXI4-Lite port clock; other domains are asynchronous.
// - A single status bit read mid-change gives old or new, never garbage.
// - Multi-bit status may be frozen by a lock bit during reads.
// - Multi-bit configuration reaches the core with a toggle; core reloads after it.
// - Undefined bits are reserved and read as zero.
// - All registers clear to zero at power-on reset.
// - Eight-bit link rate at 0x000: 0x06, 0x0A, 0x14 select bit rates.
// - Bit 0 at 0x008 turns on enhanced framing.
// - Two-bit training select at 0x00C picks off or patterns one to three.
// - Three-bit quality select at 0x010 picks the transmitted test pattern.
// - Bit 0 at 0x014 bypasses the scrambler.
// - Soft-reset register at 0x01C is write-only and reads zero.
// - Soft-reset bits 0 to 3 reset video streams one to four.
// - Soft-reset bit 7 resets the auxiliary channel.
// - Custom 80-bit pattern spans 0x020, 0x024 and low half of 0x028.
`timescale 1ns/100ps
`default_nettype none
module tlcr_regs
	import tlcr_pkg::*;
#(
	parameter int PULSE_CYCLES = SRST_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [tlcr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tlcr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output tlcr_pkg::tlcr_cfg_s cfg,
	output logic cfg_toggle,
	output logic [3:0] video_srst_toggle,
	output logic aux_srst_toggle,
	output logic [3:0] video_srst_pulse,
	output logic aux_srst_pulse
);
	import tlcr_pkg::*;

	localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

	logic [7:0] link_rate_select_ff;
	logic [4:0] active_lane_number_ff;
	logic enhanced_framing_on_ff;
	logic [1:0] training_sequence_select_ff;
	logic [2:0] quality_test_select_ff;
	logic scrambler_bypass_ff;
	logic [31:0] custom_pattern_low_ff;
	logic [31:0] custom_pattern_mid_ff;
	logic [15:0] custom_pattern_high_ff;
	logic [7:0] applied_rate_ff;
	logic [4:0] applied_lanes_ff;
	tlcr_cfg_s cfg_ff;
	logic cfg_toggle_ff;
	logic cfg_dirty_ff;
	logic [3:0] vid_tgl_ff;
	logic aux_tgl_ff;
	logic [CNT_W-1:0] vid_cnt_ff [4];
	logic [CNT_W-1:0] aux_cnt_ff;
	logic aw_hold_ff;
	logic w_hold_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic wr_fire;
	logic rd_fire;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic srst_wr;

	// Byte-lane merge of new data over old, used by the 0x020 and 0x024 pattern registers
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFF_LINK_RATE) || (a == OFF_LANES) || (a == OFF_ENH_FRAME) ||
			(a == OFF_TRAIN) || (a == OFF_QUAL) || (a == OFF_SCR_BYP) ||
			(a == OFF_SOFT_RST) || (a == OFF_PAT_LOW) || (a == OFF_PAT_MID) ||
			(a == OFF_PAT_HIGH);
	endfunction : addr_mapped

	function automatic logic rate_valid(input logic [7:0] r);
		return (r == RATE_1G62) || (r == RATE_2G7) || (r == RATE_5G4);
	endfunction : rate_valid

	function automatic logic lanes_valid(input logic [4:0] l);
		return (l == LANES_1) || (l == LANES_2) || (l == LANES_4);
	endfunction : lanes_valid

	// Soft-reset register hit with its low byte enabled
	function automatic logic srst_hit(input logic [ADDR_W-1:0] a,
		input logic [3:0] strb);
		return (a == OFF_SOFT_RST) && strb[0];
	endfunction : srst_hit

	// Address and data may arrive in either order; each is held until both are in
	assign wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
	assign wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
	assign wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
	assign wr_fire = (aw_hold_ff || s_axi_awvalid) && (w_hold_ff || s_axi_wvalid) && !bvalid_ff;
	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready = !w_hold_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign rd_fire = s_axi_arvalid && !rvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// One decode of a soft-reset write feeds both the toggles and the pulses
	assign srst_wr = wr_fire && srst_hit(wr_addr, wr_strb);

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end else if (wr_fire) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Register writes; bits outside each field are simply not stored
	always_ff @(posedge clk) begin
		if (srst) begin
			link_rate_select_ff <= REG_RESET[7:0];
			active_lane_number_ff <= REG_RESET[4:0];
			enhanced_framing_on_ff <= REG_RESET[0];
			training_sequence_select_ff <= REG_RESET[1:0];
			quality_test_select_ff <= REG_RESET[2:0];
			scrambler_bypass_ff <= REG_RESET[0];
			custom_pattern_low_ff <= REG_RESET;
			custom_pattern_mid_ff <= REG_RESET;
			custom_pattern_high_ff <= REG_RESET[15:0];
		end else if (wr_fire) begin
			unique case (wr_addr)
				OFF_LINK_RATE: link_rate_select_ff <= wr_strb[0] ? wr_data[7:0] :
					link_rate_select_ff;
				OFF_LANES: active_lane_number_ff <= wr_strb[0] ? wr_data[4:0] :
					active_lane_number_ff;
				OFF_ENH_FRAME: enhanced_framing_on_ff <= wr_strb[0] ? wr_data[0] :
					enhanced_framing_on_ff;
				OFF_TRAIN: training_sequence_select_ff <= wr_strb[0] ? wr_data[1:0] :
					training_sequence_select_ff;
				OFF_QUAL: quality_test_select_ff <= wr_strb[0] ? wr_data[2:0] :
					quality_test_select_ff;
				OFF_SCR_BYP: scrambler_bypass_ff <= wr_strb[0] ? wr_data[0] :
					scrambler_bypass_ff;
				OFF_PAT_LOW: custom_pattern_low_ff <= merge_bytes(custom_pattern_low_ff,
					wr_data, wr_strb);
				OFF_PAT_MID: custom_pattern_mid_ff <= merge_bytes(custom_pattern_mid_ff,
					wr_data, wr_strb);
				// Upper half is reserved, so only bytes 0 and 1 are kept
				OFF_PAT_HIGH: begin
					custom_pattern_high_ff[7:0] <= wr_strb[0] ? wr_data[7:0] :
						custom_pattern_high_ff[7:0];
					custom_pattern_high_ff[15:8] <= wr_strb[1] ? wr_data[15:8] :
						custom_pattern_high_ff[15:8];
				end
				default: ;
			endcase
		end
	end

	// Read path; single-cycle registered snapshot keeps each bit old or new
	always_ff @(posedge clk) begin
		if (srst) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= REG_RESET;
			rresp_ff <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			// No live status in this bank, so a plain word read stays coherent
			unique case (s_axi_araddr)
				OFF_LINK_RATE: rdata_ff <= {24'h000000, link_rate_select_ff};
				OFF_LANES: rdata_ff <= {27'h0000000, active_lane_number_ff};
				OFF_ENH_FRAME: rdata_ff <= {31'h00000000, enhanced_framing_on_ff};
				OFF_TRAIN: rdata_ff <= {30'h00000000, training_sequence_select_ff};
				OFF_QUAL: rdata_ff <= {29'h00000000, quality_test_select_ff};
				OFF_SCR_BYP: rdata_ff <= {31'h00000000, scrambler_bypass_ff};
				OFF_SOFT_RST: rdata_ff <= 32'h0000_0000;
				OFF_PAT_LOW: rdata_ff <= custom_pattern_low_ff;
				OFF_PAT_MID: rdata_ff <= custom_pattern_mid_ff;
				OFF_PAT_HIGH: rdata_ff <= {16'h0000, custom_pattern_high_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// A config write marks the snapshot stale; it is refreshed one cycle later
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_dirty_ff <= 1'b0;
		end else begin
			cfg_dirty_ff <= wr_fire && (wr_addr != OFF_SOFT_RST) && addr_mapped(wr_addr);
		end
	end

	// Undefined rate and lane codes keep the last legal value in use
	always_ff @(posedge clk) begin
		if (srst) begin
			applied_rate_ff <= REG_RESET[7:0];
			applied_lanes_ff <= REG_RESET[4:0];
		end else begin
			if (rate_valid(link_rate_select_ff)) begin
				applied_rate_ff <= link_rate_select_ff;
			end
			if (lanes_valid(active_lane_number_ff)) begin
				applied_lanes_ff <= active_lane_number_ff;
			end
		end
	end

	// Snapshot is stable between toggles, so the core may sample it after resync
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_ff <= '0;
			cfg_toggle_ff <= 1'b0;
		end else if (cfg_dirty_ff) begin
			cfg_ff.link_rate_select <= rate_valid(link_rate_select_ff) ?
				link_rate_select_ff : applied_rate_ff;
			cfg_ff.active_lane_number <= lanes_valid(active_lane_number_ff) ?
				active_lane_number_ff : applied_lanes_ff;
			cfg_ff.enhanced_framing_on <= enhanced_framing_on_ff;
			cfg_ff.training_sequence_select <= tlcr_train_e'(training_sequence_select_ff);
			cfg_ff.quality_test_select <= tlcr_qual_e'(quality_test_select_ff);
			cfg_ff.scrambler_bypass <= scrambler_bypass_ff;
			cfg_ff.custom_pattern <= {custom_pattern_high_ff, custom_pattern_mid_ff,
				custom_pattern_low_ff};
			cfg_toggle_ff <= ~cfg_toggle_ff;
		end
	end

	assign cfg = cfg_ff;
	assign cfg_toggle = cfg_toggle_ff;

	// Soft resets: a toggle per target for safe crossing, plus a local timed pulse
	always_ff @(posedge clk) begin
		if (srst) begin
			vid_tgl_ff <= '0;
			aux_tgl_ff <= 1'b0;
		end else if (srst_wr) begin
			vid_tgl_ff <= vid_tgl_ff ^ wr_data[SRST_VID_LSB +: 4];
			aux_tgl_ff <= aux_tgl_ff ^ wr_data[SRST_AUX_BIT];
		end
	end

	// Local pulses for logic on this clock; a fresh write restarts the count
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < 4; i++) begin
				vid_cnt_ff[i] <= '0;
			end
			aux_cnt_ff <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (srst_wr &&
					wr_data[SRST_VID_LSB + i]) begin
					vid_cnt_ff[i] <= CNT_W'(PULSE_CYCLES);
				end else if (vid_cnt_ff[i] != '0) begin
					vid_cnt_ff[i] <= vid_cnt_ff[i] - CNT_W'(1);
				end
			end
			if (srst_wr && wr_data[SRST_AUX_BIT]) begin
				aux_cnt_ff <= CNT_W'(PULSE_CYCLES);
			end else if (aux_cnt_ff != '0) begin
				aux_cnt_ff <= aux_cnt_ff - CNT_W'(1);
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			video_srst_pulse[i] = (vid_cnt_ff[i] != '0);
		end
	end

	assign aux_srst_pulse = (aux_cnt_ff != '0);
	assign video_srst_toggle = vid_tgl_ff;
	assign aux_srst_toggle = aux_tgl_ff;
endmodule : tlcr_regs
`default_nettype wire

// *** verification/tlcr_regs_sva.sv ***
// Assertion checker for the link configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tlcr_regs_sva
	import tlcr_pkg::*;
#(
	parameter int PULSE_CYCLES = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire tlcr_pkg::tlcr_cfg_s cfg,
	input wire logic cfg_toggle,
	input wire logic [3:0] video_srst_toggle,
	input wire logic aux_srst_toggle,
	input wire logic aux_srst_pulse
);
	logic [7:0] aux_cnt_ff;
	wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire rd_go = s_axi_arvalid && s_axi_arready;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Length of the current aux pulse, for a bound that no repetition could reach
	always_ff @(posedge clk) begin
		aux_cnt_ff <= (srst || !aux_srst_pulse) ? 8'h00 : aux_cnt_ff + 8'h01;
	end
	sequence s_srst_wr;
		wr_go && s_axi_awaddr == OFF_SOFT_RST && s_axi_wstrb[0];
	endsequence
	sequence s_rate_wr;
		wr_go && s_axi_awaddr == OFF_LINK_RATE && s_axi_wstrb[0] && s_axi_wdata[7:0] == RATE_5G4;
	endsequence
	sequence s_cfg_new;
		cfg.link_rate_select == RATE_5G4 && $changed(cfg_toggle);
	endsequence
	property p_wr_ans; wr_go |=> s_axi_bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_srst_rd; rd_go && s_axi_araddr == OFF_SOFT_RST |=> s_axi_rdata == 32'h0; endproperty
	a_srst_rd: assert property (p_srst_rd) else $error("soft reset reads nonzero");
	property p_pat_rsvd;
		rd_go && s_axi_araddr == OFF_PAT_HIGH |=> s_axi_rdata[31:16] == 16'h0;
	endproperty
	a_pat_rsvd: assert property (p_pat_rsvd) else $error("pattern high upper half set");
	property p_hole; wr_go && s_axi_awaddr == 12'h018 |=> s_axi_bresp == RESP_SLVERR; endproperty
	a_hole: assert property (p_hole) else $error("hole write not refused");
	property p_cfg; s_rate_wr |=> ##1 s_cfg_new; endproperty
	a_cfg: assert property (p_cfg) else $error("rate not applied with toggle");
	property p_vid;
		s_srst_wr |=>
			(video_srst_toggle ^ $past(video_srst_toggle)) == $past(s_axi_wdata[3:0]);
	endproperty
	a_vid: assert property (p_vid) else $error("video reset toggles wrong");
	property p_aux;
		s_srst_wr ##0 s_axi_wdata[7] |=>
			aux_srst_pulse && aux_srst_toggle != $past(aux_srst_toggle);
	endproperty
	a_aux: assert property (p_aux) else $error("aux reset missing");
	property p_aux_len; $fell(aux_srst_pulse) |-> aux_cnt_ff == PULSE_CYCLES; endproperty
	a_aux_len: assert property (p_aux_len) else $error("aux pulse length wrong");
endmodule : tlcr_regs_sva
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the link configuration register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
	import tlcr_pkg::*;
	localparam int PULSE_CYCLES = 4;
	logic clk = 1'b0, srst = 1'b1;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0, video_srst_toggle, video_srst_pulse;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic cfg_toggle, aux_srst_toggle, aux_srst_pulse;
	tlcr_cfg_s cfg;
	logic [31:0] shadow [12];
	logic [7:0] exp_rate;
	logic [4:0] exp_lanes;
	logic [7:0] rates [8] = '{8'h06, 8'h0A, 8'h14, 8'h07, 8'h14, 8'h00, 8'h0A, 8'hFF};
	int bits [5] = '{0, 1, 2, 3, 7};
	int errors = 0, cmp_count = 0, cyc = 0;
	tlcr_regs #(.PULSE_CYCLES(PULSE_CYCLES)) dut (.*);
	function automatic logic [31:0] fmask(input logic [11:0] a);
		case (a)
			OFF_LINK_RATE: return 32'hFF;
			OFF_LANES: return 32'h1F;
			OFF_ENH_FRAME, OFF_SCR_BYP: return 32'h1;
			OFF_TRAIN: return 32'h3;
			OFF_QUAL: return 32'h7;
			OFF_PAT_LOW, OFF_PAT_MID: return 32'hFFFF_FFFF;
			OFF_PAT_HIGH: return 32'hFFFF;
			default: return 32'h0;
		endcase
	endfunction : fmask
	function automatic logic mapped(input logic [11:0] a);
		return fmask(a) != 0 || a == OFF_SOFT_RST;
	endfunction : mapped
	task automatic stop_test();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	task automatic do_reset();
		srst = 1'b1;
		shadow = '{default: '0};
		exp_rate = '0;
		exp_lanes = '0;
		repeat (10) @(negedge clk);
		srst = 1'b0;
	endtask : do_reset
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic [31:0] m;
		n = 0;
		m = fmask(a) & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		shadow[a[5:2]] = (shadow[a[5:2]] & ~m) | (d & m);
		// Illegal rate or lane codes are stored but never applied
		if (a == OFF_LINK_RATE && s[0] && d[7:0] inside {RATE_1G62, RATE_2G7, RATE_5G4}) begin
			exp_rate = d[7:0];
		end
		if (a == OFF_LANES && s[0] && d[4:0] inside {LANES_1, LANES_2, LANES_4}) begin
			exp_lanes = d[4:0];
		end
		s_axi_awaddr = a;
		s_axi_wdata = d;
		s_axi_wstrb = s;
		s_axi_awvalid = 1'b1;
		s_axi_wvalid = 1'b1;
		do @(posedge clk); while (!(s_axi_awready && s_axi_wready) && ++n < 50);
		@(negedge clk);
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		@(negedge clk);
		s_axi_bready = 1'b1;
		do @(posedge clk); while (!s_axi_bvalid && ++n < 50);
		// A stalled handshake counts as an error; the run carries on to the verdict
		if (n >= 50) begin
			errors++;
		end
		`CHK("bresp", s_axi_bresp, mapped(a) ? RESP_OKAY : RESP_SLVERR)
		@(negedge clk);
		s_axi_bready = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		s_axi_araddr = a;
		s_axi_arvalid = 1'b1;
		do @(posedge clk); while (!s_axi_arready && ++n < 50);
		@(negedge clk);
		s_axi_arvalid = 1'b0;
		// One stalled cycle so the answer must hold
		@(negedge clk);
		s_axi_rready = 1'b1;
		do @(posedge clk); while (!s_axi_rvalid && ++n < 50);
		if (n >= 50) begin
			errors++;
		end
		`CHK("rdata", s_axi_rdata, fmask(a) & shadow[a[5:2]])
		`CHK("rresp", s_axi_rresp, mapped(a) ? RESP_OKAY : RESP_SLVERR)
		@(negedge clk);
		s_axi_rready = 1'b0;
	endtask : rd
	task automatic chk_cfg();
		`CHK("rate", cfg.link_rate_select, exp_rate)
		`CHK("lanes", cfg.active_lane_number, exp_lanes)
		`CHK("frame", cfg.enhanced_framing_on, shadow[2][0])
		`CHK("train", cfg.training_sequence_select, shadow[3][1:0])
		`CHK("qual", cfg.quality_test_select, shadow[4][2:0])
		`CHK("scr", cfg.scrambler_bypass, shadow[5][0])
		`CHK("pat", cfg.custom_pattern, {shadow[10][15:0], shadow[9], shadow[8]})
	endtask : chk_cfg
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		logic [3:0] tv;
		logic ta;
		logic [11:0] a;
		void'($urandom(32'hD85FD380));
		do_reset();
		for (int i = 0; i < 12; i++) rd(12'(i * 4));
		wr(12'h018, 32'hFFFF_FFFF, 4'hF);
		for (int v = 0; v < 8; v++) begin
			wr(OFF_LINK_RATE, {24'h0, rates[v]}, 4'hF);
			wr(OFF_LANES, 32'(v), 4'hF);
			wr(OFF_TRAIN, 32'(v), 4'hF);
			wr(OFF_QUAL, 32'(v % 6), 4'hF);
			wr(OFF_ENH_FRAME, 32'(v), 4'hF);
			wr(OFF_SCR_BYP, 32'(v >> 1), 4'hF);
			rd(OFF_LINK_RATE);
			rd(OFF_LANES);
			chk_cfg();
		end
		foreach (bits[i]) begin
			tv = video_srst_toggle;
			ta = aux_srst_toggle;
			wr(OFF_SOFT_RST, 32'h1 << bits[i], 4'hF);
			`CHK("vtog", video_srst_toggle, tv ^ 4'(1 << bits[i]))
			`CHK("atog", aux_srst_toggle, ta ^ (bits[i] == 7))
			`CHK("vpls", video_srst_pulse, 4'(1 << bits[i]))
			`CHK("apls", aux_srst_pulse, bits[i] == 7)
			repeat (PULSE_CYCLES) @(negedge clk);
			`CHK("pend", {video_srst_pulse, aux_srst_pulse}, 5'h00)
		end
		for (int i = 0; i < 60; i++) begin
			a = 12'(($urandom % 12) * 4);
			wr(a, $urandom, 4'($urandom));
			rd(a);
			chk_cfg();
		end
		do_reset();
		for (int i = 0; i < 12; i++) rd(12'(i * 4));
		chk_cfg();
		stop_test();
	end
endmodule : testbench
bind tlcr_regs tlcr_regs_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.*);
`default_nettype wire
